// file: srwd_top.sv
// Behaviour
// [RULE1] Reset held low while supply low.
// [RULE2] Reset held 50 or 200 ms after recovery.
// [RULE3] High reset output is complement of low.
// [RULE4] Missed toggle gives one reset pulse.
// [RULE5] Fixed variants use 1.6 s timeout.
// [RULE6] Long timeout until first toggle after reset.
// [RULE7] Watchdog restarts when reset ends.
// [RULE8] Every toggle edge restarts timeout count.
// [RULE9] Stuck toggle gives repeated long resets.
// [RULE10] Floating toggle disables the watchdog.
// [RULE11] External clock: 1024/4096 timeout, 512/2048 reset.
// [RULE12] Internal: pin high 1.6 s, low 100 ms.
// [RULE13] Internal timebase runs at 10.24 kHz.
// [RULE14] Capacitor oscillator clocks the counters.
// [RULE15] Expiry status low until next toggle.
// [RULE16] Expiry status high while supply low.
// [RULE17] Processor toggles faster than 70 ms.
// [RULE18] Backup mode ignores inputs, status high.
// [RULE19] Toggle taken as valid flag plus level.
//
// Purpose: Supervisor reset generator and watchdog timer.
// Assumes: Supply-low and backup indications are digital and synchronous.
// Notes:   Adjustable variant when i_adjustable is high; long pulse by i_long_pulse.
`timescale 1ns/100ps
`include "srwd_defs.svh"
module srwd_top (
	input  wire logic            i_core_clk,
	input  wire logic            i_rst,
	input  wire logic            i_supply_low,
	input  wire logic            i_battery_backup,
	input  wire logic            i_adjustable,
	input  wire logic            i_long_pulse,
	input  wire logic            i_timebase_source_select,
	input  wire logic            i_timebase_pin,
	input  wire logic            i_watchdog_toggle_valid,
	input  wire logic            i_watchdog_toggle_in,
	output logic                 o_reset_n,
	output logic                 o_reset,
	output logic                 o_watchdog_expired_n,
	output srwd_pkg::srwd_state_t o_state
);
	import srwd_pkg::*;

	srwd_state_t            state_q;
	logic [`SRWD_CNT_W-1:0] rst_cnt_q;
	logic [`SRWD_CNT_W-1:0] wd_cnt_q;
	logic [`SRWD_CNT_W-1:0] rst_len;
	logic [`SRWD_CNT_W-1:0] wd_len;
	logic                   long_q;
	logic                   tick;
	logic                   val_s1_q;
	logic                   val_s2_q;
	logic                   lvl_s1_q;
	logic                   lvl_s2_q;
	logic                   lvl_s3_q;
	logic                   val_s3_q;
	logic                   wd_enabled;
	logic                   toggle_edge;
	logic                   wd_expire;
	logic                   adj_sel;
	logic                   ext_sel;
	logic                   slow_pin;
	logic                   power_bad;

	// In backup the oscillator inputs are ignored and the internal timebase runs.
	assign adj_sel  = i_adjustable && !i_battery_backup; // RULE18
	assign ext_sel  = adj_sel && !i_timebase_source_select;
	assign slow_pin = !adj_sel || i_timebase_pin;
	assign power_bad = i_supply_low || i_battery_backup;

	srwd_timebase u_timebase (
		.i_core_clk               (i_core_clk),
		.i_rst                    (i_rst),
		.i_timebase_source_select (!ext_sel),
		.i_timebase_pin           (i_timebase_pin),
		.o_tick                   (tick)
	);

	// Toggle input synchronised to the core clock before edge detection.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			val_s1_q <= 1'b0;
			val_s2_q <= 1'b0;
			val_s3_q <= 1'b0;
			lvl_s1_q <= 1'b0;
			lvl_s2_q <= 1'b0;
			lvl_s3_q <= 1'b0;
		end else begin
			val_s1_q <= i_watchdog_toggle_valid; // RULE19
			val_s2_q <= val_s1_q;
			val_s3_q <= val_s2_q;
			lvl_s1_q <= i_watchdog_toggle_in;
			lvl_s2_q <= lvl_s1_q;
			lvl_s3_q <= lvl_s2_q;
		end
	end

	assign wd_enabled  = val_s2_q && !i_battery_backup; // RULE10 RULE18
	assign toggle_edge = wd_enabled && val_s3_q && (lvl_s2_q != lvl_s3_q); // RULE8

	always_comb begin
		if (ext_sel) begin
			rst_len = i_long_pulse ? `SRWD_EXT_RSTL_TICKS : `SRWD_EXT_RST_TICKS; // RULE11
		end else begin
			rst_len = i_long_pulse ? `SRWD_INT_RSTL_TICKS : `SRWD_INT_RST_TICKS; // RULE2
		end
	end

	always_comb begin
		if (ext_sel) begin
			wd_len = long_q ? `SRWD_EXT_LONG_TICKS : `SRWD_EXT_NORM_TICKS; // RULE11
		end else if (long_q || slow_pin) begin
			wd_len = `SRWD_INT_SLOW_TICKS; // RULE5 RULE6 RULE12
		end else begin
			wd_len = `SRWD_INT_FAST_TICKS; // RULE12
		end
	end

	assign wd_expire = (state_q == SRWD_RUN) && wd_enabled && !toggle_edge && tick
		&& (wd_cnt_q >= wd_len - `SRWD_CNT_W'(1)); // RULE4 RULE9

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_q   <= SRWD_RESET;
			rst_cnt_q <= '0;
		end else if (i_supply_low) begin
			state_q   <= SRWD_RESET; // RULE1
			rst_cnt_q <= '0;
		end else begin
			case (state_q)
				SRWD_RESET: begin
					state_q   <= SRWD_HOLD;
					rst_cnt_q <= '0;
				end
				SRWD_HOLD: begin
					if (tick) begin
						if (rst_cnt_q >= rst_len - `SRWD_CNT_W'(1)) begin
							state_q   <= SRWD_RUN; // RULE2
							rst_cnt_q <= '0;
						end else begin
							rst_cnt_q <= rst_cnt_q + `SRWD_CNT_W'(1);
						end
					end
				end
				SRWD_RUN: begin
					if (wd_expire) begin
						state_q <= SRWD_HOLD; // RULE4
					end
				end
				default: begin
					state_q <= SRWD_RESET;
				end
			endcase
		end
	end

	// Timeout counter restarts on every edge and whenever reset is active.
	always_ff @(posedge i_core_clk) begin
		if (i_rst || state_q != SRWD_RUN || toggle_edge || !wd_enabled) begin
			wd_cnt_q <= '0; // RULE7 RULE8
		end else if (tick) begin
			wd_cnt_q <= wd_cnt_q + `SRWD_CNT_W'(1);
		end
	end

	// Long period stands after any reset until the first toggle edge in run.
	always_ff @(posedge i_core_clk) begin
		if (i_rst || state_q != SRWD_RUN) begin
			long_q <= 1'b1; // RULE6
		end else if (toggle_edge) begin
			long_q <= 1'b0; // RULE6
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst || power_bad) begin
			o_watchdog_expired_n <= 1'b1; // RULE16 RULE18
		end else if (toggle_edge) begin
			o_watchdog_expired_n <= 1'b1; // RULE15
		end else if (wd_expire) begin
			o_watchdog_expired_n <= 1'b0; // RULE15
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_reset_n <= 1'b0;
			o_reset   <= 1'b1;
		end else begin
			o_reset_n <= (state_q == SRWD_RUN) && !i_supply_low && !wd_expire; // RULE1
			o_reset   <= !((state_q == SRWD_RUN) && !i_supply_low && !wd_expire); // RULE3
		end
	end

	assign o_state = state_q;

	reset_compl_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_reset == !o_reset_n) else $error("reset outputs not complementary"); // RULE3

	supply_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_supply_low |=> !o_reset_n) else $error("reset released while supply low"); // RULE1

	status_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		power_bad |=> o_watchdog_expired_n) else $error("status low in low supply"); // RULE16

	expire_status_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(wd_expire && !power_bad) |=> !o_watchdog_expired_n && !o_reset_n)
		else $error("expiry did not flag"); // RULE15

	edge_restart_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		toggle_edge |=> wd_cnt_q == '0) else $error("edge did not restart count"); // RULE8

	disabled_wd_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!wd_enabled |-> !wd_expire) else $error("expiry while disabled"); // RULE10

	long_after_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(state_q == SRWD_RUN) |-> long_q && wd_cnt_q == '0)
		else $error("long period not applied"); // RULE6

	hold_release_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_q == SRWD_HOLD && tick && rst_cnt_q < rst_len - `SRWD_CNT_W'(1)
		&& !i_supply_low) |=> state_q == SRWD_HOLD) else $error("reset released early"); // RULE2

	expire_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(wd_expire && !i_supply_low) |=> state_q == SRWD_HOLD) else $error("no pulse"); // RULE4

	run_cov: cover property (@(posedge i_core_clk) $rose(state_q == SRWD_RUN));
	expire_cov: cover property (@(posedge i_core_clk) wd_expire);
	edge_cov: cover property (@(posedge i_core_clk) toggle_edge && !long_q);
endmodule

// file: srwd_defs.svh
// Purpose: Constants for the supervisor reset and watchdog block.
// Assumes: Core clock of 125 MHz; timebase ticks counted in cycles of the selected source.
// Notes:   All periods are counted in timebase ticks.
`ifndef SRWD_DEFS_SVH
`define SRWD_DEFS_SVH

`define SRWD_CLK_HZ          125000000
`define SRWD_INT_OSC_HZ      10240
`define SRWD_INT_DIV         (`SRWD_CLK_HZ / `SRWD_INT_OSC_HZ)
`define SRWD_CNT_W           15
`define SRWD_DIV_W           14
`define SRWD_EXT_NORM_TICKS  15'h0400
`define SRWD_EXT_LONG_TICKS  15'h1000
`define SRWD_EXT_RST_TICKS   15'h0200
`define SRWD_EXT_RSTL_TICKS  15'h0800
`define SRWD_INT_SLOW_MS     1600
`define SRWD_INT_FAST_MS     100
`define SRWD_INT_RST_MS      50
`define SRWD_INT_RSTL_MS     200
`define SRWD_MS_TICKS(ms)    ((ms) * `SRWD_INT_OSC_HZ / 1000)
`define SRWD_INT_SLOW_TICKS  15'(`SRWD_MS_TICKS(`SRWD_INT_SLOW_MS))
`define SRWD_INT_FAST_TICKS  15'(`SRWD_MS_TICKS(`SRWD_INT_FAST_MS))
`define SRWD_INT_RST_TICKS   15'(`SRWD_MS_TICKS(`SRWD_INT_RST_MS))
`define SRWD_INT_RSTL_TICKS  15'(`SRWD_MS_TICKS(`SRWD_INT_RSTL_MS))

`endif

// file: srwd_pkg.sv
// Purpose: Types for the supervisor reset and watchdog block.
// Assumes: Nothing beyond the constants header.
// Notes:   Gray coded states along reset, hold and run.
package srwd_pkg;
	typedef enum logic [1:0] {
		SRWD_RESET = 2'h0,
		SRWD_HOLD  = 2'h1,
		SRWD_RUN   = 2'h3
	} srwd_state_t;
endpackage

// file: srwd_timebase.sv
// Purpose: Timebase tick generator for the supervisor block.
// Assumes: External clock or capacitor oscillator arrives on the timebase pin, synchronous.
// Notes:   Internal mode divides the core clock to 10.24 kHz.
`timescale 1ns/100ps
`include "srwd_defs.svh"
module srwd_timebase (
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_timebase_source_select,
	input  wire logic i_timebase_pin,
	output logic      o_tick
);
	logic [`SRWD_DIV_W-1:0] div_q;
	logic                   pin_q;
	logic                   int_tick;

	assign int_tick = (div_q == `SRWD_DIV_W'(`SRWD_INT_DIV - 1));

	always_ff @(posedge i_core_clk) begin
		if (i_rst || int_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + `SRWD_DIV_W'(1);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= i_timebase_pin;
		end
	end

	// Each rising edge of the external clock or capacitor oscillator is one tick.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_tick <= 1'b0;
		end else if (i_timebase_source_select) begin
			o_tick <= int_tick; // RULE13
		end else begin
			o_tick <= i_timebase_pin && !pin_q; // RULE14
		end
	end
endmodule

// file: srwd_cpu_model.sv
// Purpose: Processor model that services the watchdog toggle input.
// Assumes: Changes its output just after the rising core clock edge.
// Notes:   Toggles on a kick, or every i_gap+1 cycles while running.
`timescale 1ns/100ps
module srwd_cpu_model (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_run,
	input  wire logic        i_kick,
	input  wire logic [11:0] i_gap,
	output logic             o_toggle
);
	logic [11:0] cnt_q;

	initial o_toggle = 1'b0;
	initial cnt_q = 12'h000;

	// The port stays at its reset level until reset has ended.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_toggle <= 1'b0;
			cnt_q    <= 12'h000;
		end else if (i_kick || (i_run && cnt_q >= i_gap)) begin
			o_toggle <= ~o_toggle;
			cnt_q    <= 12'h000;
		end else begin
			cnt_q <= cnt_q + 12'h001;
		end
	end
endmodule

// file: srwd_tb.sv
// Purpose: Self-checking bench for the supervisor reset and watchdog.
// Assumes: External tick mode, one tick every two core cycles.
// Notes:   Checks allow four ticks of slack around each expected edge; the first watchdog expiry gets none before it and eight after.
`timescale 1ns/100ps
module tb;
	logic        clk = 0, rst = 1, sup = 0, bak = 0, lng = 0, pin = 0;
	logic        vld = 1, run = 0, kick = 0, seen_low = 0;
	logic [11:0] gap = 12'h064;
	logic        tog, rn, r, wdn;
	int          errors = 0, tests_run = 0, seed = 32'hfcff;

	always #4 clk = ~clk;

	srwd_top u_srwd_top (
		.i_core_clk(clk), .i_rst(rst), .i_supply_low(sup), .i_battery_backup(bak),
		.i_adjustable(1'b1), .i_long_pulse(lng), .i_timebase_source_select(1'b0),
		.i_timebase_pin(pin), .i_watchdog_toggle_valid(vld), .i_watchdog_toggle_in(tog),
		.o_reset_n(rn), .o_reset(r), .o_watchdog_expired_n(wdn), .o_state());
	srwd_cpu_model u_srwd_cpu_model (
		.i_clk(clk), .i_reset_n(rn), .i_run(run), .i_kick(kick), .i_gap(gap),
		.o_toggle(tog));

	always @(posedge clk) if (rn === 1'b0) seen_low <= 1'b1;

	function automatic int rst_len(input logic l);
		return l ? 2048 : 512;
	endfunction
	function automatic int wd_len(input logic after);
		return after ? 4096 : 1024;
	endfunction

	task automatic check(input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge clk) pin = 1;
			@(negedge clk) pin = 0;
		end
	endtask
	task automatic stop_test;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk);
		errors++;
		stop_test;
	end

	initial begin
		repeat (12) @(negedge clk);
		rst = 0;
		ticks(rst_len(0) - 4);
		check(rn, 0);
		check(r, 1);
		ticks(8);
		check(rn, 1);
		check(r, 0);
		ticks(wd_len(1) - 4);
		check(rn, 1);
		ticks(8);
		check(rn, 0);
		check(wdn, 0);
		ticks(rst_len(0) + 8);
		check(rn, 1);
		check(wdn, 0);
		@(negedge clk) kick = 1;
		@(negedge clk) kick = 0;
		ticks(4);
		check(wdn, 1);
		ticks(wd_len(0) - 8);
		check(rn, 1);
		ticks(8);
		check(rn, 0);
		ticks(rst_len(0) + 8);
		sup = 1;
		lng = 1;
		ticks(4);
		check(rn, 0);
		check(wdn, 1);
		sup = 0;
		ticks(rst_len(1) - 4);
		check(rn, 0);
		ticks(8);
		check(rn, 1);
		lng = 0;
		ticks(wd_len(1) - 8);
		check(rn, 1);
		ticks(8);
		check(rn, 0);
		bak = 1;
		ticks(2);
		check(wdn, 1);
		bak = 0;
		ticks(rst_len(0) + 8);
		check(rn, 1);
		repeat (3) begin
			gap = 12'h014 + 12'($unsigned($random(seed)) % 1500);
			run = 1;
			seen_low = 0;
			ticks(2000);
			check(seen_low, 0);
		end
		run = 0;
		ticks(wd_len(0) + 16);
		check(seen_low, 1);
		ticks(rst_len(0) + 8);
		vld = 0;
		seen_low = 0;
		ticks(5000);
		check(seen_low, 0);
		stop_test;
	end
endmodule
